// ---- common/pdd_map.svh ----
// pdd_map.svh: named constants for the direction decoder
// assumes a 125 MHz core clock; counts derive from the printed times
`ifndef PDD_MAP_SVH
`define PDD_MAP_SVH

`define PDD_CLK_HZ 125000000
`define PDD_PRI_HZ 977
`define PDD_SEC_HZ 871
`define PDD_TOL_HZ 10
// period windows in clocks: shortest period at f+tol, longest at f-tol
`define PDD_PRI_MIN ((`PDD_CLK_HZ + (`PDD_PRI_HZ + `PDD_TOL_HZ) - 1) / (`PDD_PRI_HZ + `PDD_TOL_HZ))
`define PDD_PRI_MAX (`PDD_CLK_HZ / (`PDD_PRI_HZ - `PDD_TOL_HZ))
`define PDD_SEC_MIN ((`PDD_CLK_HZ + (`PDD_SEC_HZ + `PDD_TOL_HZ) - 1) / (`PDD_SEC_HZ + `PDD_TOL_HZ))
`define PDD_SEC_MAX (`PDD_CLK_HZ / (`PDD_SEC_HZ - `PDD_TOL_HZ))
// duty windows in percent, each nominal plus or minus the tolerance
`define PDD_DUTY_TOL 2
`define PDD_DUTY_UNK 15
`define PDD_DUTY_PARK 30
`define PDD_DUTY_REV 45
`define PDD_DUTY_NEU 60
`define PDD_DUTY_FWD 75
`define PDD_DUTY_ERR 90
`define PDD_PCT 100
`define PDD_WARMUP_CLEAR 40
`define PDD_CNT_W 20

`endif

// ---- common/pdd_pkg.sv ----
// pdd_pkg: types shared by the direction decoder files
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package pdd_pkg;
  typedef enum logic [2:0] {
    PDD_DIR_UNKNOWN,
    PDD_DIR_PARK,
    PDD_DIR_REVERSE,
    PDD_DIR_NEUTRAL,
    PDD_DIR_FORWARD,
    PDD_DIR_ERROR,
    PDD_DIR_INVALID
  } pdd_dir_type;
endpackage : pdd_pkg
`default_nettype wire

// ---- dv/pdd_selector_model.sv ----
// pdd_selector_model: behavioural shift selector driving the backup direction wire
// assumes the bench gives period and high time in core_clk cycles and a pull-up on the wire
`default_nettype none
module pdd_selector_model (
  // clock
  input wire logic core_clk,
  // waveform setup, taken only at a period boundary
  input wire logic [19:0] period_clk,
  input wire logic [19:0] high_clk,
  // open-drain driver, high pulls the wire low
  output logic pull_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] cnt_q = 20'h0;
  logic [19:0] per_q = 20'h0;
  logic [19:0] hi_q = 20'h0;
  // new settings wait for the boundary so no period is torn
  always @(negedge core_clk) begin
    if (cnt_q + 20'h1 >= per_q) begin
      cnt_q <= 20'h0;
      per_q <= period_clk;
      hi_q <= high_clk;
    end else begin
      cnt_q <= cnt_q + 20'h1;
    end
  end
  // released for the high part of the period, pulled down for the rest
  assign pull_low = (cnt_q >= hi_q);
endmodule : pdd_selector_model
`default_nettype wire

// ---- dv/tb_pwm_direction_decoder.sv ----
// tb_pwm_direction_decoder: self-checking bench for the direction decoder
// assumes the selector model drives the wire; the decoder is told of a slower clock so periods stay short
`default_nettype none
`include "pdd_map.svh"
module tb_pwm_direction_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import pdd_pkg::*;
  localparam int TB_HZ = 1000000;
  localparam int PRI = TB_HZ / `PDD_PRI_HZ;
  localparam int SEC = TB_HZ / `PDD_SEC_HZ;
  int n_errors = 0;
  int checks = 0;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok = 1'b0;
  logic warmup_done = 1'b0;
  logic fault_erase_cmd = 1'b0;
  logic can_dir_valid = 1'b0;
  logic can_lost = 1'b0;
  pdd_dir_type can_dir = PDD_DIR_NEUTRAL;
  logic [19:0] period_clk = 20'h0;
  logic [19:0] high_clk = 20'h0;
  logic pull_low;
  wire dir_wire;
  pdd_dir_type pwm_dir;
  pdd_dir_type active_dir;
  logic pwm_dir_valid;
  logic fault;
  logic stored;
  logic lamp;
  // pull-up: the wire is high unless the selector pulls it down
  assign dir_wire = ~pull_low;
  always #4 core_clk = ~core_clk;
  pdd_selector_model partner (.core_clk(core_clk), .period_clk(period_clk), .high_clk(high_clk), .pull_low(pull_low));
  pdd_direction_decoder #(.WARMUP_CLEAR(3), .CLK_HZ(TB_HZ)) DUT (.core_clk(core_clk), .rst_n(rst_n), .dir_wire_in(dir_wire),
    .supply_ok(supply_ok), .warmup_done(warmup_done), .fault_erase_cmd(fault_erase_cmd),
    .can_dir_valid(can_dir_valid), .can_dir(can_dir), .can_lost(can_lost), .pwm_dir(pwm_dir),
    .pwm_dir_valid(pwm_dir_valid), .active_dir(active_dir), .direction_circuit_fault(fault),
    .fault_stored(stored), .driver_warning_lamp(lamp));
  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // lamp, stored and active fault packed in that order
  task automatic flags(input logic [2:0] exp);
    check("lamp_stored_fault", {lamp, stored, fault}, exp);
  endtask : flags
  // two rising edges: one to take the new setting, one to close a clean period
  task automatic send(input int per, input int pct);
    period_clk = per[19:0];
    high_clk = 20'(per * pct / 100);
    repeat (2) @(posedge dir_wire);
    repeat (8) @(negedge core_clk);
  endtask : send
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : pulse
  // off-nominal duties inside each window
  task automatic t_decode;
    int pct[6] = '{14, 31, 44, 61, 76, 89};
    for (int i = 0; i < 6; i++) begin
      send(PRI, pct[i]);
      check("pwm_dir", pwm_dir, 3'(i));
      check("pwm_dir_valid", {2'h0, pwm_dir_valid}, 3'h1);
    end
    send(SEC, 60);
    check("pwm_dir secondary", pwm_dir, PDD_DIR_NEUTRAL);
    flags(3'h0);
    $display("test decode done");
  endtask : t_decode
  task automatic t_can;
    for (int i = 1; i < 5; i++) begin
      can_dir = pdd_dir_type'(i);
      can_dir_valid = 1'b1;
      repeat (4) @(negedge core_clk);
      check("active_dir can", active_dir, 3'(i));
    end
    can_dir_valid = 1'b0;
    can_lost = 1'b1;
    send(PRI, 45);
    check("active_dir wire", active_dir, PDD_DIR_REVERSE);
    $display("test can done");
  endtask : t_can
  task automatic t_fault;
    supply_ok = 1'b0;
    send(PRI, 80);
    check("pwm_dir bad duty", pwm_dir, PDD_DIR_INVALID);
    flags(3'h0);
    supply_ok = 1'b1;
    send(2 * PRI, 60);
    flags(3'h7);
    send(PRI, 75);
    check("active_dir held", active_dir, PDD_DIR_REVERSE);
    pulse(fault_erase_cmd);
    flags(3'h0);
    send(PRI, 75);
    check("active_dir resumed", active_dir, PDD_DIR_FORWARD);
    $display("test fault done");
  endtask : t_fault
  task automatic t_warm;
    send(PRI, 80);
    flags(3'h7);
    send(PRI, 60);
    // the first pulse closes the warm-up in which the fault happened, so it does not count
    repeat (3) pulse(warmup_done);
    check("stored early", {2'h0, stored}, 3'h1);
    pulse(warmup_done);
    check("stored cleared", {2'h0, stored}, 3'h0);
    flags(3'h0);
    $display("test warmup done");
  endtask : t_warm
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // main sequence; supply stays low over the first period, measured from reset
  initial begin
    repeat (12) @(negedge core_clk);
    check("reset pwm_dir", pwm_dir, PDD_DIR_INVALID);
    rst_n = 1'b1;
    send(PRI, 60);
    flags(3'h0);
    supply_ok = 1'b1;
    t_decode();
    t_can();
    t_fault();
    t_warm();
    final_report();
  end
  // watchdog: some fifteen waveform changes of about two periods each need well under this
  initial begin
    repeat (90000) @(posedge core_clk);
    n_errors++;
    final_report();
  end
endmodule : tb_pwm_direction_decoder
`default_nettype wire

// ---- logic/pdd_direction_decoder.sv ----
// pdd_direction_decoder: measures the backup direction wire and runs fault reactions
// assumes the wire is asynchronous to core_clk; supply window and can status come from other logic
//
// What this block does
// - duty cycle is high time over period
// - accept primary or secondary selector frequency
// - decode six duty windows into direction codes
// - invalid decoded data raises the circuit fault
// - fault lights lamp and logs history
// - ignore pulse input while fault active
// - no can while faulted: hold last valid
// - forty clean warm-ups erase stored fault
// - service tool command erases stored fault
// - can is primary path, wire monitored too
// - evaluate fault only within supply window
`default_nettype none
`include "pdd_map.svh"
module pdd_direction_decoder #(
  parameter int CNT_W = `PDD_CNT_W,
  parameter int WARMUP_CLEAR = `PDD_WARMUP_CLEAR,
  parameter int CLK_HZ = `PDD_CLK_HZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // direction wire (open drain, receive only)
  input wire logic dir_wire_in,
  // supply monitor and vehicle events
  input wire logic supply_ok,
  input wire logic warmup_done,
  input wire logic fault_erase_cmd,
  // can data link direction
  input wire logic can_dir_valid,
  input wire pdd_pkg::pdd_dir_type can_dir,
  input wire logic can_lost,
  // results
  output pdd_pkg::pdd_dir_type pwm_dir,
  output logic pwm_dir_valid,
  output pdd_pkg::pdd_dir_type active_dir,
  output logic direction_circuit_fault,
  output logic fault_stored,
  output logic driver_warning_lamp
);
  import pdd_pkg::*;

  // period windows in clocks follow the clock parameter, so a slower test clock keeps periods short
  // shortest period at nominal plus tolerance (rounded up), longest at nominal minus tolerance
  localparam int PRI_F_HI = `PDD_PRI_HZ + `PDD_TOL_HZ;
  localparam int PRI_F_LO = `PDD_PRI_HZ - `PDD_TOL_HZ;
  localparam int SEC_F_HI = `PDD_SEC_HZ + `PDD_TOL_HZ;
  localparam int SEC_F_LO = `PDD_SEC_HZ - `PDD_TOL_HZ;
  localparam logic [CNT_W-1:0] PRI_MIN = CNT_W'((CLK_HZ + PRI_F_HI - 1) / PRI_F_HI);
  localparam logic [CNT_W-1:0] PRI_MAX = CNT_W'(CLK_HZ / PRI_F_LO);
  localparam logic [CNT_W-1:0] SEC_MIN = CNT_W'((CLK_HZ + SEC_F_HI - 1) / SEC_F_HI);
  localparam logic [CNT_W-1:0] SEC_MAX = CNT_W'(CLK_HZ / SEC_F_LO);

  logic sync1_q, sync2_q, prev_q;
  logic [CNT_W-1:0] per_cnt_q, high_cnt_q, per_lat_q, high_lat_q;
  logic meas_q;
  logic fault_q, stored_q;
  logic [6:0] clean_q;
  logic warm_bad_q;
  pdd_dir_type pwm_dir_q, active_q, last_valid_q;
  logic pwm_valid_q;

  // two-stage synchroniser; the first flop feeds nothing but the second
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      sync1_q <= dir_wire_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // period starts at a rising edge: line released, selector driver off
  wire rise = sync2_q && !prev_q;
  wire per_full = &per_cnt_q;

  // count period and the high part of it; a stuck line saturates and reads invalid
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      per_cnt_q <= '0;
      high_cnt_q <= '0;
      per_lat_q <= '0;
      high_lat_q <= '0;
      meas_q <= 1'b0;
    end else if (rise) begin
      per_lat_q <= per_cnt_q;
      high_lat_q <= high_cnt_q;
      meas_q <= 1'b1;
      per_cnt_q <= CNT_W'(1);
      high_cnt_q <= CNT_W'(1);
    end else begin
      meas_q <= per_full; // stuck line also forces a verdict
      if (per_full) begin
        per_lat_q <= per_cnt_q;
        high_lat_q <= high_cnt_q;
      end
      per_cnt_q <= per_full ? per_cnt_q : per_cnt_q + CNT_W'(1);
      high_cnt_q <= (sync2_q && !per_full) ? high_cnt_q + CNT_W'(1) : high_cnt_q;
    end
  end

  // period check against either selector, only the active one sends
  wire pri_ok = (per_lat_q >= PRI_MIN) && (per_lat_q <= PRI_MAX);
  wire sec_ok = (per_lat_q >= SEC_MIN) && (per_lat_q <= SEC_MAX);
  wire period_ok = pri_ok || sec_ok;

  pdd_dir_type duty_dir;
  pdd_duty_class #(
    .CNT_W(CNT_W)
  ) u_class (
    .high_cnt(high_lat_q),
    .period_cnt(per_lat_q),
    .dir_code(duty_dir)
  );

  wire [2:0] decoded = period_ok ? duty_dir : PDD_DIR_INVALID;
  wire bad_data = meas_q && (decoded == PDD_DIR_INVALID);
  wire bad_eval = bad_data && supply_ok;

  // a warm-up counts as clean only if no bad frame fell inside it; the fault that
  // started a streak spoils the warm-up it happened in, so the streak starts after it
  wire warm_clean = warmup_done && !warm_bad_q;
  wire warm_erase = warm_clean && (clean_q == 7'(WARMUP_CLEAR - 1));

  // decoded direction and fault flag
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pwm_dir_q <= PDD_DIR_INVALID;
      pwm_valid_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      if (meas_q) begin
        pwm_dir_q <= pdd_dir_type'(decoded);
        pwm_valid_q <= !bad_data;
      end
      // fault stays active until a clear; a new bad frame wins over the clear
      if (bad_eval)
        fault_q <= 1'b1;
      else if (fault_erase_cmd || warm_erase)
        fault_q <= 1'b0;
    end
  end

  // history and warm-up clearing; a fault in the same cycle wins over erase
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stored_q <= 1'b0;
      clean_q <= '0;
      warm_bad_q <= 1'b0;
    end else begin
      if (bad_eval)
        stored_q <= 1'b1;
      else if (fault_erase_cmd || warm_erase)
        stored_q <= 1'b0;
      if (bad_eval || fault_erase_cmd || !stored_q)
        clean_q <= '0;
      else if (warmup_done)
        clean_q <= warm_clean ? clean_q + 7'h01 : 7'h00;
      warm_bad_q <= warmup_done ? bad_eval : (warm_bad_q || bad_eval);
    end
  end

  // can is the main path; wire backs it up unless faulted
  wire use_pwm = !fault_q && pwm_valid_q && (pwm_dir_q != PDD_DIR_ERROR)
                 && (pwm_dir_q != PDD_DIR_UNKNOWN);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      active_q <= PDD_DIR_NEUTRAL;
      last_valid_q <= PDD_DIR_NEUTRAL;
    end else if (!can_lost && can_dir_valid) begin
      active_q <= can_dir;
      last_valid_q <= can_dir;
    end else if (can_lost && use_pwm) begin
      active_q <= pwm_dir_q;
      last_valid_q <= pwm_dir_q;
    end else if (can_lost) begin
      active_q <= last_valid_q;
    end
  end

  assign pwm_dir = pwm_dir_q;
  assign pwm_dir_valid = pwm_valid_q;
  assign active_dir = active_q;
  assign direction_circuit_fault = fault_q;
  assign fault_stored = stored_q;
  assign driver_warning_lamp = fault_q;

  // a bad frame inside the supply window must raise the fault on the next edge
  chk_fault_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    bad_eval |=> direction_circuit_fault) else $error("fault not raised on bad data");

  // the lamp and the history never lag the active fault
  chk_lamp_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    direction_circuit_fault |-> driver_warning_lamp && fault_stored) else $error("lamp or history missing");

  // while faulted and without can, the wire value must never reach the output
  chk_ignore_pwm: assert property (@(posedge core_clk) disable iff (!rst_n)
    (direction_circuit_fault && can_lost) |=> active_dir == $past(last_valid_q)) else $error("pwm used while faulted");

  // two faulted cycles without can: the direction in use stays frozen
  chk_hold_last: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fault_q && can_lost) ##1 (fault_q && can_lost) |=> $stable(active_dir)) else $error("direction not held");

  // a brown-out can produce garbage frames; they must not raise the fault
  chk_supply_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!supply_ok && !direction_circuit_fault && !fault_erase_cmd) |=> !direction_circuit_fault)
    else $error("fault set outside supply window");

  // a tool erase with no fresh bad frame clears both history and fault
  chk_tool_erase: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fault_erase_cmd && !bad_eval) |=> !fault_stored && !direction_circuit_fault) else $error("erase ignored");

  // history only ever drops through an erase or a full clean streak
  chk_warm_erase: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(fault_stored) |-> $past(fault_erase_cmd) || $past(clean_q) == 7'(WARMUP_CLEAR - 1))
    else $error("history cleared too early");

  // a period outside both selector windows is never reported as valid
  chk_period_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (meas_q && !period_ok) |=> !pwm_dir_valid) else $error("bad period accepted");

  // high time is counted inside the period, so it can never exceed it
  chk_duty_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    rise |=> high_lat_q <= per_lat_q) else $error("high time above period");

  // a bad frame is also written to the history on the next edge
  chk_stored_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    bad_eval |=> fault_stored) else $error("history not written");

  // the active fault is sticky until something clears it
  chk_fault_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    (direction_circuit_fault && !fault_erase_cmd && !warm_erase) |=> direction_circuit_fault)
    else $error("fault dropped without a clear");

  // the history is sticky until something clears it
  chk_stored_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fault_stored && !fault_erase_cmd && !warm_erase) |=> fault_stored) else $error("history dropped");

  // can wins whenever it is present and valid
  chk_can_path: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!can_lost && can_dir_valid) |=> active_dir == $past(can_dir)) else $error("can direction not taken");

  // without can, a usable wire value becomes the direction in use
  chk_pwm_backup: assert property (@(posedge core_clk) disable iff (!rst_n)
    (can_lost && use_pwm) |=> active_dir == $past(pwm_dir_q)) else $error("backup wire not used");

  // a frame flagged valid always carries a real direction code
  chk_valid_code: assert property (@(posedge core_clk) disable iff (!rst_n)
    pwm_dir_valid |-> pwm_dir != PDD_DIR_INVALID) else $error("valid flag on invalid code");

  // a good period with a duty inside a window is reported as valid
  chk_good_frame: assert property (@(posedge core_clk) disable iff (!rst_n)
    (meas_q && period_ok && duty_dir != PDD_DIR_INVALID) |=> pwm_dir_valid) else $error("good frame rejected");

  // a duty between the windows is rejected whatever the period
  chk_bad_duty: assert property (@(posedge core_clk) disable iff (!rst_n)
    (meas_q && duty_dir == PDD_DIR_INVALID) |=> !pwm_dir_valid) else $error("bad duty accepted");

  // the decoded code only moves when a measurement closes
  chk_dir_steady: assert property (@(posedge core_clk) disable iff (!rst_n)
    !meas_q |=> $stable(pwm_dir)) else $error("direction moved between frames");

  // a spoiled warm-up restarts the streak from zero
  chk_streak_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    (warmup_done && warm_bad_q) |=> clean_q == 7'h00) else $error("streak kept after bad warm-up");

  // the last clean warm-up of a streak clears history and fault together
  chk_warm_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (warm_erase && !bad_eval) |=> !fault_stored && !direction_circuit_fault) else $error("streak did not clear");

  // each rising edge of the wire restarts the period count
  chk_period_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    rise |=> per_cnt_q == CNT_W'(1)) else $error("period count not restarted");

  // a stuck line keeps the counter saturated until the line rises again
  chk_sat_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (per_full && !rise) |=> per_full) else $error("saturated counter wrapped");
endmodule : pdd_direction_decoder
`default_nettype wire

// ---- logic/pdd_duty_class.sv ----
// pdd_duty_class: maps one measured high time and period onto a direction code
// assumes high_cnt never exceeds period_cnt
`default_nettype none
`include "pdd_map.svh"
module pdd_duty_class #(
  parameter int CNT_W = `PDD_CNT_W
) (
  // measurement
  input wire logic [CNT_W-1:0] high_cnt,
  input wire logic [CNT_W-1:0] period_cnt,
  // result
  output pdd_pkg::pdd_dir_type dir_code
);
  import pdd_pkg::*;

  // compare high*100 against period*(nominal +/- tol); no division needed
  // high*100 as 64+32+4, every term widened to the full result
  wire [CNT_W+7:0] high_pct = {2'h0, high_cnt, 6'h00} + {3'h0, high_cnt, 5'h00} + {6'h00, high_cnt, 2'h0};

  function automatic logic in_win(input logic [CNT_W+7:0] hp, input logic [CNT_W-1:0] per,
                                  input int nom);
    logic [CNT_W+7:0] lo;
    logic [CNT_W+7:0] hi;
    lo = (CNT_W+8)'(per * (nom - `PDD_DUTY_TOL));
    hi = (CNT_W+8)'(per * (nom + `PDD_DUTY_TOL));
    in_win = (hp >= lo) && (hp <= hi);
  endfunction : in_win

  wire w_unk = in_win(high_pct, period_cnt, `PDD_DUTY_UNK);
  wire w_park = in_win(high_pct, period_cnt, `PDD_DUTY_PARK);
  wire w_rev = in_win(high_pct, period_cnt, `PDD_DUTY_REV);
  wire w_neu = in_win(high_pct, period_cnt, `PDD_DUTY_NEU);
  wire w_fwd = in_win(high_pct, period_cnt, `PDD_DUTY_FWD);
  wire w_err = in_win(high_pct, period_cnt, `PDD_DUTY_ERR);

  // windows never overlap, so priority order only matters for none-hit
  assign dir_code = w_unk ? PDD_DIR_UNKNOWN :
                    w_park ? PDD_DIR_PARK :
                    w_rev ? PDD_DIR_REVERSE :
                    w_neu ? PDD_DIR_NEUTRAL :
                    w_fwd ? PDD_DIR_FORWARD :
                    w_err ? PDD_DIR_ERROR : PDD_DIR_INVALID;
endmodule : pdd_duty_class
`default_nettype wire
